// *** verilog/gdc_pkg.sv ***
// Constants and types shared by the gate drive control design
package gdc_pkg;

	// Supply state codes for each supply rail input
	typedef enum logic [1:0]
	{
		GDC_SUP_PD   = 2'h0,
		GDC_SUP_PU   = 2'h1,
		GDC_SUP_OPEN = 2'h2
	} gdc_supply_t;

	// Fault latch states, one-hot
	typedef enum logic [3:0]
	{
		GDC_FLT_OK    = 4'h1,
		GDC_FLT_MUTE  = 4'h2,
		GDC_FLT_HELD  = 4'h4,
		GDC_FLT_ARMED = 4'h8
	} gdc_flt_state_t;

	// Clock and timing
	localparam int CLK_FREQ_KHZ   = 100000;
	localparam int CLK_PERIOD_NS  = 10;
	localparam int FILTER_TIME_NS = 40;
	localparam int FILTER_CYC     =
		(FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_FILT_NS    = 1000;
	localparam int RST_FILT_CYC   =
		(RST_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MUTE_NS        = 10000;
	localparam int MUTE_CYC       =
		(MUTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Monitor waveform
	localparam int PWM_FREQ_KHZ   = 400;
	localparam int PWM_PERIOD_CYC = CLK_FREQ_KHZ / PWM_FREQ_KHZ;
	localparam int PWM_DUTY_MIN   = 5;
	localparam int PWM_DUTY_MAX   = 95;
	localparam int CODE_FULL      = 255;

	// Register map, byte addresses
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_MASK   = 4'h4;
	localparam logic [3:0] REG_STATE  = 4'h8;

	// Event bits of status and mask
	localparam int EV_FAULT = 0;
	localparam int EV_UVLO  = 1;
	localparam int EV_ASC   = 2;
	localparam int EV_W     = 3;

	// Reset values
	localparam logic [EV_W-1:0] STATUS_RST = 3'h0;
	localparam logic [EV_W-1:0] MASK_RST   = 3'h0;

	// Filtered input lanes
	localparam int LANE_INP = 0;
	localparam int LANE_INN = 1;
	localparam int LANE_RST = 2;
	localparam int LANES    = 3;

endpackage

// *** verilog/gdc_filt_if.sv ***
// Carrier between pin synchronisers and the deglitch filter
`timescale 1ns/1ps
interface gdc_filt_if #(parameter int N = 3);
	logic [N-1:0] raw;
	logic [N-1:0] clean;
	modport src (output raw, input clean);
	modport fault_n_out (input raw, output clean);
endinterface

// *** verilog/gdc_deglitch.sv ***
// Per-lane deglitch filter rejecting short pulses
`timescale 1ns/1ps
module gdc_deglitch
#(
	parameter int FILT_CYC = 4,
	parameter int N        = 3
)
(
	input  wire logic   i_ref_clk,
	input  wire logic   i_rst_n,
	gdc_filt_if.fault_n_out     bus
);

	localparam int CW = $clog2(FILT_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(FILT_CYC - 1);

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_lane
			logic [CW-1:0] cnt_q;
			logic          out_q;

			// Output follows only after FILT_CYC differing cycles
			always_ff @(posedge i_ref_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
				begin
					cnt_q <= '0;
					out_q <= 1'b0;
				end
				else if (bus.raw[g] == out_q)
					cnt_q <= '0;
				else if (cnt_q == LAST)
				begin
					cnt_q <= '0;
					out_q <= bus.raw[g];
				end
				else
					cnt_q <= cnt_q + CW'(1);
			end

			assign bus.clean[g] = out_q;
		end
	endgenerate

endmodule

// *** verilog/gdc_top.sv ***
// Gate drive control: supply table, fault latch, monitor, registers
// Summary of operation
// - Active short with output supplies up: gate on, clamp off, fault freed.
// - Monitor pin carries short level as 400 kHz PWM, 5% to 95%.
// - Either output supply down with enable high: gate off, not ready.
// - Positive output supply down, no short: gate off, clamp off, not ready.
// - Input supply down, no short: gate off, clamp on, not ready.
// - Enable low with supplies up, no short: gate off, clamp on, ready released.
// - Positive output supply open: gate and clamp float, not ready.
// - Negative output supply open: gate off, clamp on, not ready.
// - Noninverting input low, no short: gate off, clamp on.
// - Outside active short, inverting input high forces gate off, clamp on.
// - Outside active short, gate on only with supplies up, enabled, no fault, inputs high and low.
// - Overcurrent shuts gate and latches fault low until reset.
// - Undervoltage pulls gate down, shows not ready, recovers alone.
// - Fault clears on enable rising after low beyond reset filter time.
// - Reset requests ignored during fault mute time.
// - Pulses under 40 ns on PWM and enable inputs are rejected.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module gdc_top
#(
	parameter int P_RST_FILT_CYC = gdc_pkg::RST_FILT_CYC,
	parameter int P_MUTE_CYC     = gdc_pkg::MUTE_CYC
)
(
	input  wire logic               i_ref_clk,
	input  wire logic               i_reset_n,
	input  wire gdc_pkg::gdc_supply_t i_vcc_state,
	input  wire gdc_pkg::gdc_supply_t i_vdd_state,
	input  wire gdc_pkg::gdc_supply_t i_vee_state,
	input  wire logic               i_in_pos,
	input  wire logic               i_in_neg,
	input  wire logic               i_rst_en,
	input  wire logic               i_active_short_request,
	input  wire logic [7:0]         i_short_level_code,
	input  wire logic               i_overcurrent_sense,
	input  wire logic               i_fault_n_in,
	input  wire logic               i_power_good_in,
	input  wire logic [3:0]         i_reg_addr,
	input  wire logic [7:0]         i_reg_wdata,
	input  wire logic               i_reg_wr,
	input  wire logic               i_reg_rd,
	output logic [7:0]              o_reg_rdata,
	output logic                    o_irq,
	output logic                    o_gate_drive_out,
	output logic                    o_gate_drive_out_oe,
	output logic                    o_miller_clamp_drive,
	output logic                    o_miller_clamp_drive_oe,
	output logic                    o_fault_n_out,
	output logic                    o_fault_n_out_oe,
	output logic                    o_power_good,
	output logic                    o_power_good_oe,
	output logic                    o_short_level_pwm_monitor
);
	import gdc_pkg::*;

	localparam int TW = 16;
	localparam logic [TW-1:0] RST_LAST  = TW'(P_RST_FILT_CYC - 1);
	localparam logic [TW-1:0] MUTE_LAST = TW'(P_MUTE_CYC - 1);
	localparam logic [7:0] PWM_LAST = 8'(PWM_PERIOD_CYC - 1);
	localparam int DUTY_BASE = PWM_PERIOD_CYC * PWM_DUTY_MIN + 50;
	localparam int DUTY_SPAN =
		PWM_PERIOD_CYC * (PWM_DUTY_MAX - PWM_DUTY_MIN);
	localparam int SW = 7;

	logic            rst_ff1_q;
	logic            rst_n;
	logic [SW-1:0]   sync1_q;
	logic [SW-1:0]   sync2_q;
	logic            inp_f;
	logic            inn_f;
	logic            rst_f;
	logic            rst_f_q;
	logic            asc_s;
	logic            oc_s;
	gdc_flt_state_t  flt_q;
	logic [TW-1:0]   tmr_q;
	logic            fault_q;
	logic            all_pu;
	logic            asc_row;
	logic            on_cond;
	logic            gate_d;
	logic            clamp_d;
	logic            drv_oe_d;
	logic            pg_low_d;
	logic            gate_q;
	logic            clamp_q;
	logic            drv_oe_q;
	logic            pg_low_q;
	logic            flt_oe_q;
	logic [7:0]      pwm_cnt_q;
	logic [7:0]      duty_q;
	logic [7:0]      duty_d;
	logic            pwm_q;
	logic [EV_W-1:0] status_q;
	logic [EV_W-1:0] mask_q;
	logic [EV_W-1:0] ev;
	logic            asc_row_q;

	gdc_filt_if #(.N(LANES)) filt ();

	// Reset release through two flops
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			rst_ff1_q <= 1'b0;
			rst_n     <= 1'b0;
		end
		else
		begin
			rst_ff1_q <= 1'b1;
			rst_n     <= rst_ff1_q;
		end
	end

	// Two-flop synchronisers for pin inputs
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= {i_power_good_in, i_fault_n_in,
				i_overcurrent_sense, i_active_short_request,
				i_rst_en, i_in_neg, i_in_pos};
			sync2_q <= sync1_q;
		end
	end

	assign filt.raw = sync2_q[2:0];
	assign asc_s    = sync2_q[3];
	assign oc_s     = sync2_q[4];

	gdc_deglitch #(.FILT_CYC(FILTER_CYC), .N(LANES)) u_deglitch
	(
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (rst_n),
		.bus       (filt)
	);

	assign inp_f = filt.clean[LANE_INP];
	assign inn_f = filt.clean[LANE_INN];
	assign rst_f = filt.clean[LANE_RST];

	// Previous filtered enable for edge detection
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_f_q <= 1'b0;
		else
			rst_f_q <= rst_f;
	end

	// Fault latch with mute and reset filter timing
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flt_q <= GDC_FLT_OK;
			tmr_q <= '0;
		end
		else
		begin
			case (flt_q)
				GDC_FLT_OK:
				begin
					tmr_q <= '0;
					if (oc_s && gate_q)
						flt_q <= GDC_FLT_MUTE;
				end
				GDC_FLT_MUTE:
				begin
					if (tmr_q == MUTE_LAST)
					begin
						tmr_q <= '0;
						flt_q <= GDC_FLT_HELD;
					end
					else
						tmr_q <= tmr_q + TW'(1);
				end
				GDC_FLT_HELD:
				begin
					if (rst_f)
						tmr_q <= '0;
					else if (tmr_q == RST_LAST)
						flt_q <= GDC_FLT_ARMED;
					else
						tmr_q <= tmr_q + TW'(1);
				end
				GDC_FLT_ARMED:
				begin
					if (rst_f && !rst_f_q)
						flt_q <= GDC_FLT_OK;
				end
				default:
				begin
					flt_q <= GDC_FLT_MUTE;
					tmr_q <= '0;
				end
			endcase
		end
	end

	assign fault_q = (flt_q != GDC_FLT_OK);
	assign all_pu  = (i_vcc_state == GDC_SUP_PU)
		&& (i_vdd_state == GDC_SUP_PU) && (i_vee_state == GDC_SUP_PU);
	assign on_cond = all_pu && rst_f && !fault_q && inp_f && !inn_f;

	// Supply and input priority table, evaluated every cycle
	always_comb
	begin
		gate_d   = 1'b0;
		clamp_d  = 1'b1;
		drv_oe_d = 1'b1;
		pg_low_d = 1'b1;
		asc_row  = 1'b0;
		if (asc_s && i_vdd_state == GDC_SUP_PU
			&& i_vee_state == GDC_SUP_PU)
		begin
			gate_d   = 1'b1;
			clamp_d  = 1'b0;
			pg_low_d = !all_pu;
			asc_row  = 1'b1;
		end
		else if (i_vdd_state == GDC_SUP_OPEN)
		begin
			drv_oe_d = 1'b0;
			clamp_d  = 1'b0;
		end
		else if (i_vdd_state == GDC_SUP_PD)
			clamp_d = 1'b0;
		else if (i_vcc_state != GDC_SUP_PU)
			clamp_d = 1'b1;
		else if (i_vee_state != GDC_SUP_PU)
			clamp_d = 1'b1;
		else
		begin
			pg_low_d = 1'b0;
			if (on_cond)
			begin
				gate_d  = 1'b1;
				clamp_d = 1'b0;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gate_q    <= 1'b0;
			clamp_q   <= 1'b1;
			drv_oe_q  <= 1'b1;
			pg_low_q  <= 1'b1;
			flt_oe_q  <= 1'b0;
			asc_row_q <= 1'b0;
		end
		else
		begin
			gate_q    <= gate_d;
			clamp_q   <= clamp_d;
			drv_oe_q  <= drv_oe_d;
			pg_low_q  <= pg_low_d;
			asc_row_q <= asc_row;
			// fault pin pulled low, freed in short row
			flt_oe_q  <= fault_q && !asc_row;
		end
	end

	assign o_gate_drive_out        = gate_q;
	assign o_gate_drive_out_oe     = drv_oe_q;
	assign o_miller_clamp_drive    = clamp_q;
	assign o_miller_clamp_drive_oe = drv_oe_q;
	assign o_fault_n_out           = 1'b0;
	assign o_fault_n_out_oe        = flt_oe_q;
	assign o_power_good            = 1'b0;
	assign o_power_good_oe         = pg_low_q;

	// Duty in cycles from the sampled level code
	always_comb
	begin
		duty_d = 8'((DUTY_BASE + int'(i_short_level_code) * DUTY_SPAN
			/ CODE_FULL) / 100);
	end

	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwm_cnt_q <= '0;
			duty_q    <= '0;
			pwm_q     <= 1'b0;
		end
		else
		begin
			if (pwm_cnt_q == PWM_LAST)
			begin
				pwm_cnt_q <= '0;
				duty_q    <= duty_d;
			end
			else
				pwm_cnt_q <= pwm_cnt_q + 8'h01;
			pwm_q <= (pwm_cnt_q < duty_q);
		end
	end

	assign o_short_level_pwm_monitor = pwm_q;

	// Event pulses for the status register
	assign ev[EV_FAULT] = (flt_q == GDC_FLT_OK) && oc_s && gate_q;
	assign ev[EV_UVLO]  = pg_low_d && !pg_low_q;
	assign ev[EV_ASC]   = asc_row && !asc_row_q;

	// Sticky status, write one to clear, set wins
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			status_q <= STATUS_RST;
		else if (i_reg_wr && i_reg_addr == REG_STATUS)
			status_q <= (status_q & ~i_reg_wdata[EV_W-1:0]) | ev;
		else
			status_q <= status_q | ev;
	end

	// Interrupt mask
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			mask_q <= MASK_RST;
		else if (i_reg_wr && i_reg_addr == REG_MASK)
			mask_q <= i_reg_wdata[EV_W-1:0];
	end

	assign o_irq = |(status_q & mask_q);

	// Read data, valid only the cycle after the strobe
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			o_reg_rdata <= '0;
		else if (!i_reg_rd)
			o_reg_rdata <= '0;
		else
		begin
			case (i_reg_addr)
				REG_STATUS: o_reg_rdata <= {5'h00, status_q};
				REG_MASK:   o_reg_rdata <= {5'h00, mask_q};
				REG_STATE:  o_reg_rdata <= {1'b0, asc_row_q,
					sync2_q[6], sync2_q[5], clamp_q, gate_q,
					!pg_low_q, fault_q};
				default:    o_reg_rdata <= '0;
			endcase
		end
	end

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_asc_forces_on: assert property (
		asc_row |=> gate_q && !clamp_q && !flt_oe_q && drv_oe_q)
		else $error("short request did not force gate on");

	a_pwm_period: assert property (
		pwm_cnt_q == 8'h00 |-> ##250 pwm_cnt_q == 8'h00)
		else $error("monitor period wrong");

	a_duty_held: assert property (
		pwm_cnt_q != 8'h00 |-> $stable(duty_q))
		else $error("duty changed mid period");

	a_vdd_down_off: assert property (
		!asc_s && i_vdd_state == GDC_SUP_PD
		|=> !gate_q && !clamp_q && pg_low_q)
		else $error("positive supply down outputs wrong");

	a_vcc_down_off: assert property (
		!asc_row && i_vcc_state == GDC_SUP_PD
		&& i_vdd_state == GDC_SUP_PU && i_vee_state == GDC_SUP_PU
		|=> !gate_q && clamp_q && pg_low_q)
		else $error("input supply down outputs wrong");

	a_enable_low: assert property (
		!asc_row && all_pu && !rst_f
		|=> !gate_q && clamp_q && !pg_low_q)
		else $error("enable low did not turn gate off");

	a_vdd_open_hiz: assert property (
		!asc_s && i_vdd_state == GDC_SUP_OPEN
		|=> !drv_oe_q && pg_low_q)
		else $error("open supply did not float outputs");

	a_interlock_off: assert property (
		!asc_row && all_pu && inn_f |=> !gate_q && clamp_q)
		else $error("inverting input did not block gate");

	a_gate_on_cause: assert property (
		gate_q |-> $past(on_cond) || $past(asc_row))
		else $error("gate on without cause");

	a_fault_latched: assert property (
		fault_q && !(flt_q == GDC_FLT_ARMED && rst_f && !rst_f_q)
		|=> fault_q)
		else $error("fault released early");

	a_mute_ignore: assert property (
		flt_q == GDC_FLT_MUTE |=> flt_q != GDC_FLT_OK)
		else $error("fault released during mute");

endmodule

// *** bench/gdc_host_model.sv ***
// Host controller model: PWM and enable pins, open-drain read-back
`timescale 1ns/1ps
module gdc_host_model
(
	input  wire logic i_ref_clk,
	input  wire logic i_fault_oe,
	input  wire logic i_ready_oe,
	output logic      o_in_pos,
	output logic      o_in_neg,
	output logic      o_rst_en,
	output logic      o_fault_n,
	output logic      o_power_good
);
	// Board pull-ups on both open-drain lines
	assign o_fault_n    = i_fault_oe ? 1'b0 : 1'b1;
	assign o_power_good = i_ready_oe ? 1'b0 : 1'b1;

	// Driver disabled until the host enables it
	initial
	begin
		o_in_pos = 1'b0;
		o_in_neg = 1'b0;
		o_rst_en = 1'b0;
	end

	// Pin levels change just after an edge
	task automatic drive(input logic p, input logic n, input logic e);
		@(posedge i_ref_clk);
		o_in_pos <= p;
		o_in_neg <= n;
		o_rst_en <= e;
	endtask

	task automatic pulse_reset(input int n);
		@(posedge i_ref_clk);
		o_rst_en <= 1'b0;
		repeat (n) @(posedge i_ref_clk);
		o_rst_en <= 1'b1;
	endtask
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the gate drive control block
`timescale 1ns/1ps
module tb;
	import gdc_pkg::*;
	localparam int RST_CYC = 8;
	localparam int MUTE_T  = 60;
	logic        clk;
	logic        rst_n;
	gdc_supply_t vcc;
	gdc_supply_t vdd;
	gdc_supply_t vee;
	logic        pos, neg, en, active_short_request, oc, flt_n, pg_in;
	logic [7:0]  code;
	logic [3:0]  addr;
	logic [7:0]  wdata;
	logic        wr, rd;
	logic [7:0]  rdata;
	logic        irq, gate, gate_oe, clamp, clamp_oe;
	logic        fault_n_out, flt_oe, pg, pg_oe, mon;
	int          fail_count;
	int          n_tests;

	gdc_top #(.P_RST_FILT_CYC(RST_CYC), .P_MUTE_CYC(MUTE_T)) i_gdc_top
	(
		.i_ref_clk(clk), .i_reset_n(rst_n),
		.i_vcc_state(vcc), .i_vdd_state(vdd), .i_vee_state(vee),
		.i_in_pos(pos), .i_in_neg(neg), .i_rst_en(en),
		.i_active_short_request(active_short_request), .i_short_level_code(code),
		.i_overcurrent_sense(oc), .i_fault_n_in(flt_n),
		.i_power_good_in(pg_in), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdata), .o_irq(irq),
		.o_gate_drive_out(gate), .o_gate_drive_out_oe(gate_oe),
		.o_miller_clamp_drive(clamp),
		.o_miller_clamp_drive_oe(clamp_oe),
		.o_fault_n_out(fault_n_out), .o_fault_n_out_oe(flt_oe),
		.o_power_good(pg), .o_power_good_oe(pg_oe),
		.o_short_level_pwm_monitor(mon)
	);

	gdc_host_model i_gdc_host_model
	(
		.i_ref_clk(clk), .i_fault_oe(flt_oe), .i_ready_oe(pg_oe),
		.o_in_pos(pos), .o_in_neg(neg), .o_rst_en(en),
		.o_fault_n(flt_n), .o_power_good(pg_in)
	);

	// Free-running 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Wait n edges, then let outputs settle
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Pin view: pin levels, oe mismatch, oe, gate, clamp, fault, ready
	function automatic logic [7:0] pins();
		return {fault_n_out, pg, clamp_oe ^ gate_oe, gate_oe, gate & gate_oe,
			clamp & clamp_oe, flt_oe, pg_oe};
	endfunction

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// One supply row with the gate inputs asking for on
	task automatic row(input gdc_supply_t c, input gdc_supply_t d,
		input gdc_supply_t s, input logic e, input logic [7:0] exp);
		@(posedge clk);
		vcc <= c;
		vdd <= d;
		vee <= s;
		i_gdc_host_model.drive(1'b1, 1'b0, e);
		tick(12);
		check(pins(), exp);
	endtask

	task automatic t_table();
		row(GDC_SUP_PU, GDC_SUP_PD, GDC_SUP_PU, 1'b1, 8'h11);
		row(GDC_SUP_PU, GDC_SUP_PU, GDC_SUP_PD, 1'b1, 8'h15);
		row(GDC_SUP_PD, GDC_SUP_PU, GDC_SUP_PU, 1'b1, 8'h15);
		row(GDC_SUP_PU, GDC_SUP_PU, GDC_SUP_PU, 1'b0, 8'h14);
		row(GDC_SUP_PU, GDC_SUP_OPEN, GDC_SUP_PU, 1'b1, 8'h01);
		row(GDC_SUP_PU, GDC_SUP_PU, GDC_SUP_OPEN, 1'b1, 8'h15);
		row(GDC_SUP_PU, GDC_SUP_PU, GDC_SUP_PU, 1'b1, 8'h18);
	endtask

	task automatic t_inputs();
		i_gdc_host_model.drive(1'b1, 1'b1, 1'b1);
		tick(12);
		check(pins(), 8'h14);
		i_gdc_host_model.drive(1'b0, 1'b0, 1'b1);
		tick(12);
		check(pins(), 8'h14);
		// Three-cycle glitch on the noninverting pin
		i_gdc_host_model.drive(1'b1, 1'b0, 1'b1);
		repeat (2) @(posedge clk);
		i_gdc_host_model.drive(1'b0, 1'b0, 1'b1);
		tick(12);
		check(pins(), 8'h14);
		i_gdc_host_model.drive(1'b1, 1'b0, 1'b1);
		tick(12);
		check(pins(), 8'h18);
	endtask

	// Short request wins over lost input supply and disable
	task automatic t_short();
		@(posedge clk);
		vcc <= GDC_SUP_PD;
		active_short_request <= 1'b1;
		i_gdc_host_model.drive(1'b0, 1'b1, 1'b0);
		tick(12);
		check(pins() & 8'h1e, 8'h18);
		@(posedge clk);
		vcc <= GDC_SUP_PU;
		active_short_request <= 1'b0;
		i_gdc_host_model.drive(1'b1, 1'b0, 1'b1);
		tick(12);
		check(pins(), 8'h18);
	endtask

	task automatic t_fault();
		@(posedge clk);
		oc <= 1'b1;
		tick(6);
		check(pins(), 8'h16);
		@(posedge clk);
		oc <= 1'b0;
		// Reset attempt inside the mute window
		i_gdc_host_model.pulse_reset(20);
		tick(12);
		check({7'h0, flt_oe}, 8'h01);
		tick(MUTE_T);
		i_gdc_host_model.pulse_reset(RST_CYC + 12);
		tick(12);
		check(pins(), 8'h18);
	endtask

	task automatic t_regs();
		logic [7:0] d;
		reg_rd(REG_STATUS, d);
		check(d, 8'h07);
		reg_rd(REG_MASK, d);
		check({d[6:0], irq}, 8'h00);
		reg_wr(REG_MASK, 8'h01);
		tick(1);
		check({7'h0, irq}, 8'h01);
		reg_rd(REG_MASK, d);
		check(d, 8'h01);
		reg_wr(REG_STATUS, 8'h01);
		reg_rd(REG_STATUS, d);
		check({d[6:0], irq}, 8'h0c);
		reg_wr(REG_STATE, 8'hff);
		reg_rd(REG_STATE, d);
		check(d, 8'h36);
		reg_rd(4'hc, d);
		check(d, 8'h00);
	endtask

	// High time and period of the monitor for one code
	task automatic measure(input logic [7:0] c);
		int h;
		int p;
		int e;
		e = (PWM_PERIOD_CYC * (PWM_DUTY_MIN * CODE_FULL
			+ c * (PWM_DUTY_MAX - PWM_DUTY_MIN)) + 50 * CODE_FULL)
			/ (100 * CODE_FULL);
		h = 0;
		p = 0;
		@(posedge clk);
		code <= c;
		tick(600);
		while (mon !== 1'b0) tick(1);
		while (mon !== 1'b1) tick(1);
		while (mon === 1'b1)
		begin
			h++;
			p++;
			tick(1);
		end
		while (mon !== 1'b1)
		begin
			p++;
			tick(1);
		end
		check(h[7:0], e[7:0]);
		check(p[7:0], 8'(PWM_PERIOD_CYC));
	endtask

	// Main sequence
	initial
	begin
		fail_count = 0;
		n_tests    = 0;
		rst_n = 1'b0;
		vcc   = GDC_SUP_PU;
		vdd   = GDC_SUP_PU;
		vee   = GDC_SUP_PU;
		active_short_request   = 1'b0;
		oc    = 1'b0;
		code  = 8'h00;
		addr  = 4'h0;
		wdata = 8'h00;
		wr    = 1'b0;
		rd    = 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		tick(3);
		t_table();
		t_inputs();
		t_short();
		t_fault();
		t_regs();
		measure(8'h00);
		measure(8'hff);
		conclude();
	end

	// Watchdog against a hang
	initial
	begin
		#200000;
		fail_count++;
		conclude();
	end
endmodule
